// *** watchdog_and_reset_control.sv ***
// Watchdog timer and reset control, registers on APB.
// Assumes clk_i is the slow internal oscillator and reset_i is power-on reset.
`include "wdt_rst_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module watchdog_and_reset_control
    import wdt_rst_pkg::*;
#(
    parameter int FAULT_DELAY_CYC = `FAULT_DELAY_DEF,
    parameter int LV_FILTER_CYC = `LV_FILTER_DEF
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic low_supply_i,
    output logic device_reset_o,
    output logic pc_sp_clear_o,
    output logic wdt_running_o,
    output logic lowvolt_armed_o
);
    initial begin
        if (FAULT_DELAY_CYC < 1 || FAULT_DELAY_CYC > 65535 || LV_FILTER_CYC < 1 || LV_FILTER_CYC > 65535) begin
            $error("Delay parameters out of range");
        end
    end

    localparam logic [15:0] FAULT_LAST = 16'(FAULT_DELAY_CYC - 1);
    localparam logic [15:0] LV_LAST = 16'(LV_FILTER_CYC);

    state_s cur_ff;
    state_s nxt_st;
    logic lsup_meta_ff;
    logic lsup_sync_ff;

    logic access;
    logic wr;
    logic rd;
    logic hit_watchdog_control;
    logic hit_flags;
    logic hit_low_voltage_reset_control;
    logic hit_status;
    logic hit_cmd;
    logic wdt_key_bad;
    logic lv_key_bad;
    logic wdt_on;
    logic lv_on;
    logic tick;
    logic [7:0] pre_mask;
    logic do_clr;
    logic do_halt;
    logic do_wake;
    logic overflow;

    // Low supply comes from an analog comparator outside this domain
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            lsup_meta_ff <= 1'b0;
            lsup_sync_ff <= 1'b0;
        end else if (clk_en_i) begin
            lsup_meta_ff <= low_supply_i;
            lsup_sync_ff <= lsup_meta_ff;
        end
    end

    always_comb begin
        // One transfer per access phase: the cycle that shows pready takes nothing again
        access = psel_i && penable_i && !cur_ff.pready;
        wr = access && pwrite_i;
        rd = access && !pwrite_i;
        hit_watchdog_control = paddr_i == `OFS_WATCHDOG_CONTROL;
        hit_flags = paddr_i == `OFS_RESET_CAUSE_FLAGS;
        hit_low_voltage_reset_control = paddr_i == `OFS_LOWVOLT_CONTROL;
        hit_status = paddr_i == `OFS_STATUS;
        hit_cmd = paddr_i == `OFS_COMMAND;
        wdt_key_bad = cur_ff.watchdog_control.wdt_enable_key != `WDT_KEY_ON
            && cur_ff.watchdog_control.wdt_enable_key != `WDT_KEY_OFF;
        lv_key_bad = cur_ff.lowvolt_select_key != `LV_KEY_ON
            && cur_ff.lowvolt_select_key != `LV_KEY_OFF;
        wdt_on = cur_ff.watchdog_control.wdt_enable_key == `WDT_KEY_ON && cur_ff.seq == RUN_ST;
        lv_on = cur_ff.lowvolt_select_key == `LV_KEY_ON && !cur_ff.standby;
        // Divide 2^n ahead of a fixed 2^8 count; CLRWDT clears the prescaler along with the count
        pre_mask = 8'((9'h001 << cur_ff.watchdog_control.wdt_period_sel) - 9'h001);
        tick = wdt_on && ((cur_ff.prescale & pre_mask) == pre_mask);
        overflow = tick && cur_ff.wdt_count == 8'hFF;
        do_clr = wr && hit_cmd && pwdata_i[`CMD_CLRWDT_BIT];
        do_halt = wr && hit_cmd && pwdata_i[`CMD_HALT_BIT];
        do_wake = wr && hit_cmd && pwdata_i[`CMD_WAKE_BIT];
    end

    always_comb begin
        nxt_st = cur_ff;
        nxt_st.pready = access;
        nxt_st.pc_sp_clear = 1'b0;
        if (rd) begin
            unique case (1'b1)
                hit_watchdog_control: nxt_st.prdata = {24'h000000, cur_ff.watchdog_control};
                hit_flags: nxt_st.prdata = {29'h00000000, cur_ff.lowvolt_reset_flag,
                    cur_ff.lowvolt_key_fault_flag, cur_ff.wdt_key_fault_flag};
                hit_low_voltage_reset_control: nxt_st.prdata = {24'h000000, cur_ff.lowvolt_select_key};
                hit_status: nxt_st.prdata = {27'h0000000, cur_ff.standby, wdt_on,
                    cur_ff.seq != RUN_ST, cur_ff.timeout_flag, cur_ff.powerdown_flag};
                default: nxt_st.prdata = 32'h00000000;
            endcase
        end
        if (wr && hit_watchdog_control) begin
            nxt_st.watchdog_control = pwdata_i[7:0];
        end
        if (wr && hit_low_voltage_reset_control) begin
            nxt_st.lowvolt_select_key = pwdata_i[7:0];
        end
        // Software may only clear; a cause in the same cycle wins below
        if (wr && hit_flags) begin
            nxt_st.wdt_key_fault_flag = cur_ff.wdt_key_fault_flag & pwdata_i[0];
            nxt_st.lowvolt_key_fault_flag = cur_ff.lowvolt_key_fault_flag & pwdata_i[1];
            nxt_st.lowvolt_reset_flag = cur_ff.lowvolt_reset_flag & pwdata_i[2];
        end
        if (do_wake) begin
            nxt_st.standby = 1'b0;
        end
        if (tick) begin
            nxt_st.prescale = cur_ff.prescale + 8'h01;
            if ((cur_ff.prescale & pre_mask) == pre_mask) begin
                nxt_st.prescale = cur_ff.prescale & ~pre_mask;
                nxt_st.wdt_count = cur_ff.wdt_count + 8'h01;
            end
        end else if (wdt_on) begin
            nxt_st.prescale = cur_ff.prescale + 8'h01;
        end
        if (do_clr) begin
            nxt_st.wdt_count = 8'h00;
            nxt_st.prescale = 8'h00;
            nxt_st.powerdown_flag = 1'b0;
        end
        if (do_halt) begin
            nxt_st.wdt_count = 8'h00;
            nxt_st.prescale = 8'h00;
            nxt_st.powerdown_flag = 1'b1;
            nxt_st.timeout_flag = 1'b0;
            nxt_st.standby = 1'b1;
        end
        if (lv_on && lsup_sync_ff) begin
            if (cur_ff.lv_cnt != LV_LAST) begin
                nxt_st.lv_cnt = cur_ff.lv_cnt + 16'h0001;
            end
        end else begin
            nxt_st.lv_cnt = 16'h0000;
        end
        if (overflow) begin
            nxt_st.timeout_flag = 1'b1;
            nxt_st.wdt_count = 8'h00;
            if (cur_ff.standby) begin
                nxt_st.pc_sp_clear = 1'b1;
                nxt_st.standby = 1'b0;
            end
        end
        unique case (cur_ff.seq)
            RUN_ST: begin
                if (overflow && !cur_ff.standby) begin
                    nxt_st.seq = RESET_ST;
                    nxt_st.rst_cnt = 4'h0;
                end else if (cur_ff.lv_cnt == LV_LAST) begin
                    nxt_st.seq = RESET_ST;
                    nxt_st.rst_cnt = 4'h0;
                    nxt_st.lowvolt_reset_flag = 1'b1;
                    nxt_st.lv_cnt = 16'h0000;
                end else if (wdt_key_bad || lv_key_bad) begin
                    nxt_st.seq = FAULT_WAIT_ST;
                    nxt_st.fault_cnt = 16'h0000;
                    nxt_st.wdt_fault_pend = wdt_key_bad;
                    nxt_st.lv_fault_pend = lv_key_bad;
                    nxt_st.wdt_count = 8'h00;
                    nxt_st.prescale = 8'h00;
                end
            end
            FAULT_WAIT_ST: begin
                nxt_st.fault_cnt = cur_ff.fault_cnt + 16'h0001;
                if (cur_ff.fault_cnt == FAULT_LAST) begin
                    nxt_st.seq = RESET_ST;
                    nxt_st.rst_cnt = 4'h0;
                    nxt_st.wdt_key_fault_flag = cur_ff.wdt_key_fault_flag | cur_ff.wdt_fault_pend;
                    nxt_st.lowvolt_key_fault_flag = cur_ff.lowvolt_key_fault_flag
                        | cur_ff.lv_fault_pend;
                    if (cur_ff.lv_fault_pend) begin
                        nxt_st.lowvolt_select_key = `LOW_VOLTAGE_RESET_CONTROL_RESET;
                    end
                    if (cur_ff.wdt_fault_pend) begin
                        nxt_st.watchdog_control = `WATCHDOG_CONTROL_RESET;
                    end
                end
            end
            RESET_ST: begin
                // Device reset held a few cycles; key registers keep their values
                nxt_st.rst_cnt = cur_ff.rst_cnt + 4'h1;
                nxt_st.wdt_count = 8'h00;
                nxt_st.prescale = 8'h00;
                nxt_st.standby = 1'b0;
                if (cur_ff.rst_cnt == 4'(`RST_PULSE_CYC - 1)) begin
                    nxt_st.seq = RUN_ST;
                end
            end
            default: nxt_st.seq = RUN_ST;
        endcase
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cur_ff <= '0;
            cur_ff.watchdog_control <= `WATCHDOG_CONTROL_RESET;
            cur_ff.lowvolt_select_key <= `LOW_VOLTAGE_RESET_CONTROL_RESET;
            cur_ff.seq <= RUN_ST;
        end else if (clk_en_i) begin
            cur_ff <= nxt_st;
        end
    end

    // Power-on: PC cleared and ports driven high by the core while reset_i is high
    assign device_reset_o = reset_i || cur_ff.seq == RESET_ST;
    assign pc_sp_clear_o = cur_ff.pc_sp_clear;
    assign wdt_running_o = wdt_on;
    assign lowvolt_armed_o = lv_on;
    assign prdata_o = cur_ff.prdata;
    assign pready_o = cur_ff.pready;
    assign pslverr_o = cur_ff.pready && !(hit_watchdog_control || hit_flags || hit_low_voltage_reset_control || hit_status || hit_cmd);
endmodule : watchdog_and_reset_control
`default_nettype wire

// *** watchdog_and_reset_control_chk.sv ***
// Port checker of the watchdog and reset control.
// Assumes it is bound to the top module and sees only its ports.
`include "wdt_rst_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module watchdog_and_reset_control_chk (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic device_reset_o,
    input wire logic pc_sp_clear_o,
    input wire logic wdt_running_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    ready_pulse_a: assert property (pready_o |=> !pready_o) else $error("pready held too long");
    answer_due_a: assert property (psel_i && penable_i && clk_en_i && !pready_o |=> pready_o)
        else $error("no answer one cycle into access");
    err_with_ready_a: assert property (pslverr_o |-> pready_o) else $error("pslverr without pready");
    unmapped_zero_a: assert property (pslverr_o && !pwrite_i |-> prdata_o == 32'h0)
        else $error("unmapped read not zero");
    flag_upper_zero_a: assert property (pready_o && !pwrite_i && paddr_i == `OFS_RESET_CAUSE_FLAGS
        |-> prdata_o[31:3] == 29'h0) else $error("flag upper bits not zero");
    // Internal reset sequence is a fixed four-cycle pulse
    reset_len_a: assert property ($rose(device_reset_o) |-> device_reset_o [*4])
        else $error("reset pulse too short");
    running_off_a: assert property (device_reset_o |-> !wdt_running_o) else $error("watchdog runs in reset");
    pcsp_no_reset_a: assert property (pc_sp_clear_o |-> !device_reset_o)
        else $error("standby overflow gave full reset");
endmodule : watchdog_and_reset_control_chk
bind watchdog_and_reset_control watchdog_and_reset_control_chk u_chk (.clk_i(clk_i), .reset_i(reset_i),
    .clk_en_i(clk_en_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .device_reset_o(device_reset_o),
    .pc_sp_clear_o(pc_sp_clear_o), .wdt_running_o(wdt_running_o));
`default_nettype wire

// *** watchdog_and_reset_control_tb.sv ***
// Self-checking bench of the watchdog and reset control.
// Assumes a 100 ns clock and shortened fault and filter counts.
`include "wdt_rst_defines.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module watchdog_and_reset_control_tb;
    localparam int FDLY = 4;
    localparam int LVF = 2;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pw = 0, ls = 0, er;
    logic [11:0] pa = 12'h000;
    logic [31:0] pwd = 32'h0, prd, rd;
    logic prdy, perr, drst, pcsp, wrun, larm;
    int err_count = 0, n_compared = 0, n;
    // Clock enable stays high: frozen operation is not exercised
    watchdog_and_reset_control #(.FAULT_DELAY_CYC(FDLY), .LV_FILTER_CYC(LVF)) dut (.clk_i(clk), .reset_i(rst),
        .clk_en_i(1'b1), .psel_i(psel), .penable_i(pen), .pwrite_i(pw), .paddr_i(pa), .pwdata_i(pwd),
        .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr), .low_supply_i(ls), .device_reset_o(drst),
        .pc_sp_clear_o(pcsp), .wdt_running_o(wrun), .lowvolt_armed_o(larm));
    initial begin
        forever #50 clk = ~clk;
    end
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : finish_test
    // Request held until pready is seen high at a rising edge; answer taken at that edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        pw <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (prdy !== 1'b1 && k < 20) begin
            k++;
            @(posedge clk);
        end
        rd = prd;
        er = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        `CHK(prdy, 1'b1)
    endtask : apb
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask : rdc
    task automatic wait_rst(input int lim);
        n = 0;
        while (drst !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
        end
        while (drst === 1'b1) @(negedge clk);
    endtask : wait_rst
    task automatic s_por();
        rdc(`OFS_WATCHDOG_CONTROL, 32'h57);
        rdc(`OFS_LOWVOLT_CONTROL, 32'h5A);
        apb(1'b0, `OFS_RESET_CAUSE_FLAGS, 32'h0);
        `CHK(rd & 32'hFFFFFFFB, 32'h0)
        `CHK({wrun, larm}, 2'b11)
        apb(1'b1, 12'h014, 32'h1);
        `CHK(er, 1'b1)
        rdc(12'h014, 32'h0);
        `CHK(er, 1'b1)
    endtask : s_por
    task automatic s_timeout();
        apb(1'b1, `OFS_WATCHDOG_CONTROL, 32'h50);
        apb(1'b1, `OFS_COMMAND, 32'h1);
        wait_rst(400);
        `CHK(n >= 250 && n <= 258, 1'b1)
        apb(1'b0, `OFS_STATUS, 32'h0);
        `CHK(rd[1], 1'b1)
    endtask : s_timeout
    task automatic s_halt();
        int p, q;
        p = 0;
        q = 0;
        apb(1'b1, `OFS_WATCHDOG_CONTROL, 32'h50);
        apb(1'b1, `OFS_COMMAND, 32'h2);
        rdc(`OFS_STATUS, 32'h19);
        `CHK(larm, 1'b0)
        repeat (300) begin
            @(negedge clk);
            p += (pcsp === 1'b1);
            q += (drst === 1'b1);
        end
        `CHK({p, q}, {32'd1, 32'd0})
        rdc(`OFS_STATUS, 32'h0B);
        apb(1'b1, `OFS_COMMAND, 32'h1);
        apb(1'b0, `OFS_STATUS, 32'h0);
        `CHK(rd[0], 1'b0)
        apb(1'b1, `OFS_WATCHDOG_CONTROL, 32'hA8);
        `CHK(wrun, 1'b0)
        wait_rst(300);
        `CHK(n, 300)
    endtask : s_halt
    task automatic s_keys();
        apb(1'b1, `OFS_WATCHDOG_CONTROL, 32'hF8);
        wait_rst(20);
        `CHK(n >= FDLY - 2 && n <= FDLY + 3, 1'b1)
        rdc(`OFS_RESET_CAUSE_FLAGS, 32'h1);
        apb(1'b1, `OFS_RESET_CAUSE_FLAGS, 32'h6);
        rdc(`OFS_RESET_CAUSE_FLAGS, 32'h0);
        apb(1'b1, `OFS_LOWVOLT_CONTROL, 32'h33);
        wait_rst(20);
        `CHK(n >= FDLY - 2 && n <= FDLY + 3, 1'b1)
        rdc(`OFS_RESET_CAUSE_FLAGS, 32'h2);
        rdc(`OFS_LOWVOLT_CONTROL, 32'h5A);
        apb(1'b1, `OFS_RESET_CAUSE_FLAGS, 32'h0);
    endtask : s_keys
    task automatic s_lowvolt();
        @(posedge clk) ls <= 1'b1;
        @(posedge clk) ls <= 1'b0;
        wait_rst(10);
        `CHK(n, 10)
        apb(1'b1, `OFS_LOWVOLT_CONTROL, 32'hA5);
        `CHK(larm, 1'b0)
        @(posedge clk) ls <= 1'b1;
        wait_rst(12);
        `CHK(n, 12)
        apb(1'b1, `OFS_LOWVOLT_CONTROL, 32'h5A);
        wait_rst(12);
        `CHK(n < 12, 1'b1)
        @(posedge clk) ls <= 1'b0;
        rdc(`OFS_RESET_CAUSE_FLAGS, 32'h4);
        rdc(`OFS_LOWVOLT_CONTROL, 32'h5A);
        apb(1'b1, `OFS_RESET_CAUSE_FLAGS, 32'h0);
        rdc(`OFS_RESET_CAUSE_FLAGS, 32'h0);
    endtask : s_lowvolt
    initial begin
        #500000;
        err_count++;
        finish_test();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        s_por();
        s_timeout();
        s_halt();
        s_keys();
        s_lowvolt();
        finish_test();
    end
endmodule : watchdog_and_reset_control_tb
`default_nettype wire

// *** wdt_rst_defines.svh ***
// Offsets, reset values, keys and timing counts of the watchdog and reset control.
// Assumes inclusion by bare name from the design, checker and bench files.
`ifndef WDT_RST_DEFINES_SVH
`define WDT_RST_DEFINES_SVH
`define OFS_WATCHDOG_CONTROL 12'h000
`define OFS_RESET_CAUSE_FLAGS 12'h004
`define OFS_LOWVOLT_CONTROL 12'h008
`define OFS_STATUS 12'h00C
`define OFS_COMMAND 12'h010
`define WATCHDOG_CONTROL_RESET 8'h57
`define LOW_VOLTAGE_RESET_CONTROL_RESET 8'h5A
`define WDT_KEY_OFF 5'h15
`define WDT_KEY_ON 5'h0A
`define LV_KEY_ON 8'h5A
`define LV_KEY_OFF 8'hA5
`define KEY_POS 3
`define SEL_POS 0
`define CMD_CLRWDT_BIT 0
`define CMD_HALT_BIT 1
`define CMD_WAKE_BIT 2
`define FAULT_DELAY_DEF 16
`define LV_FILTER_DEF 4
`define RST_PULSE_CYC 4
`endif

// *** wdt_rst_pkg.sv ***
// Types shared by the watchdog and reset control.
// Assumes the defines header is on the include path.
package wdt_rst_pkg;
    typedef struct packed {
        logic [4:0] wdt_enable_key;
        logic [2:0] wdt_period_sel;
    } wdt_ctrl_s;
    typedef enum logic [1:0] {
        RUN_ST = 2'b00,
        FAULT_WAIT_ST = 2'b01,
        RESET_ST = 2'b10
    } seq_e;
    typedef struct packed {
        wdt_ctrl_s watchdog_control;
        logic [7:0] lowvolt_select_key;
        logic lowvolt_reset_flag;
        logic lowvolt_key_fault_flag;
        logic wdt_key_fault_flag;
        logic timeout_flag;
        logic powerdown_flag;
        logic standby;
        logic [7:0] prescale;
        logic [7:0] wdt_count;
        logic [15:0] fault_cnt;
        logic [15:0] lv_cnt;
        logic [3:0] rst_cnt;
        seq_e seq;
        logic wdt_fault_pend;
        logic lv_fault_pend;
        logic pc_sp_clear;
        logic [31:0] prdata;
        logic pready;
    } state_s;
endpackage : wdt_rst_pkg
